/* rtl/lacc_defines.svh */
`ifndef LACC_DEFINES_SVH
`define LACC_DEFINES_SVH
// Behaviour
// - Unfiltered load reading refreshes once per full step so a stall is seen in time.
// - With filter enabled, reading is the average of four consecutive measurements.
// - Load reading is 10-bit unsigned; lower value means higher load.
// - Lower threshold zero disables adaptive control; else raise current below threshold*32.
// - Upper threshold is (lower+hysteresis+1)*32; lower current after enough readings there.
// - Each reading below lower threshold adds 1, 2, 4 or 8 to the scale.
// - Scale drops by one after 32, 8, 2 or 1 readings at or above upper.
// - Adaptive control never drops scale below half or quarter of run current.
// - Readable 5-bit present scale, bounded by run current and selected minimum under adaptive control; otherwise run or hold current.
// - Filter cuts measurement rate and regulation speed by four.
// - Adaptive control only between velocity thresholds; otherwise run or hold current.
// - Signed sensitivity offsets the reading; higher values reduce sensitivity.

// Register offsets (byte addresses)
`define LACC_OFS_CTRL     8'h00
`define LACC_OFS_CURRENT  8'h04
`define LACC_OFS_VLOW     8'h08
`define LACC_OFS_UPPER_VELOCITY_THRESHOLD    8'h0c
`define LACC_OFS_STATUS   8'h10
`define LACC_OFS_IRQ_STS  8'h14
`define LACC_OFS_IRQ_MASK 8'h18

// Control register fields
`define LACC_CTRL_LOWER_LSB 0
`define LACC_CTRL_HYST_LSB  4
`define LACC_CTRL_INC_LSB   8
`define LACC_CTRL_DEC_LSB   10
`define LACC_CTRL_MIN_BIT   12
`define LACC_CTRL_FILT_BIT  13
`define LACC_CTRL_SENS_LSB  16

// Current register fields
`define LACC_CUR_RUN_LSB  0
`define LACC_CUR_HOLD_LSB 8

// Status register fields
`define LACC_STAT_SCALE_LSB 16
`define LACC_STAT_ACT_BIT   24

// Interrupt bits
`define LACC_IRQ_NEW   0
`define LACC_IRQ_STALL 1
`define LACC_IRQ_RAISE 2
`define LACC_IRQ_LOWER 3
`define LACC_IRQ_W     4

// Reset values
`define LACC_RST_RUN  5'h1f
`define LACC_RST_HOLD 5'h08

// Threshold scale (shift by 5 = times 32), sensitivity shift (times 16)
`define LACC_THR_SHIFT 5
`define LACC_SENS_SHIFT 4
`endif

/* rtl/lacc_pkg.sv */
package lacc_pkg;
  typedef struct packed {
    logic signed [6:0] sens;
    logic              filt;
    logic              min_sel;
    logic [1:0]        dec;
    logic [1:0]        inc;
    logic [3:0]        hyst;
    logic [3:0]        lower;
  } lacc_cfg_s;

  typedef struct packed {
    logic       valid;
    logic [9:0] data;
  } lacc_meas_s;

  typedef enum logic {
    LACC_FIXED,
    LACC_ADAPT
  } lacc_state_e;
endpackage

/* rtl/lacc_load_filter.sv */
`timescale 1ns/1ps
module lacc_load_filter #(
  parameter int DW       = 10,
  parameter int TAPS_LOG = 2
) (
  input  wire logic                clk_i,
  input  wire logic                reset_n_i,
  input  wire logic                en_i,
  input  wire lacc_pkg::lacc_meas_s in_i,
  output lacc_pkg::lacc_meas_s     out_o
);
  logic [DW+TAPS_LOG-1:0] acc_q;
  logic [DW+TAPS_LOG-1:0] acc_d;
  logic [DW+TAPS_LOG-1:0] acc_sum;
  logic [TAPS_LOG-1:0]    cnt_q;
  logic [TAPS_LOG-1:0]    cnt_d;
  lacc_pkg::lacc_meas_s   out_q;
  lacc_pkg::lacc_meas_s   out_d;

  always_comb
  begin
    acc_sum = acc_q + (DW+TAPS_LOG)'(in_i.data);
    acc_d   = acc_q;
    cnt_d   = cnt_q;
    out_d   = '{valid: 1'b0, data: out_q.data};
    if (in_i.valid)
    begin
      if (!en_i)
      begin
        out_d = in_i;
        acc_d = '0;
        cnt_d = '0;
      end
      else if (&cnt_q)
      begin
        // Average by dropping the low bits: cheaper than a divider
        out_d = '{valid: 1'b1, data: acc_sum[DW+TAPS_LOG-1:TAPS_LOG]};
        acc_d = '0;
        cnt_d = '0;
      end
      else
      begin
        acc_d = acc_sum;
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      acc_q <= '0;
      cnt_q <= '0;
      out_q <= '0;
    end
    else
    begin
      acc_q <= acc_d;
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  assign out_o = out_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  raw_pass_a: assert property (!en_i && in_i.valid |=> out_o.valid && out_o.data == $past(in_i.data))
    else $error("unfiltered reading not passed on");
  filt_fourth_a: assert property (en_i && in_i.valid && (&cnt_q) |=> out_o.valid)
    else $error("filtered reading missing after fourth sample");
  filt_rate_a: assert property (en_i && !(in_i.valid && (&cnt_q)) |=> !out_o.valid)
    else $error("filtered reading produced too often");
endmodule

/* rtl/lacc_top.sv */
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "lacc_defines.svh"
module lacc_top #(
  parameter int VEL_W = 20
) (
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire logic [7:0]       addr_i,
  input  wire logic [31:0]      wdata_i,
  input  wire logic             wr_i,
  input  wire logic             rd_i,
  output logic      [31:0]      rd_data_o,
  input  wire logic             fullstep_i,
  input  wire logic [9:0]       raw_load_i,
  input  wire logic [VEL_W-1:0] velocity_i,
  input  wire logic             standstill_i,
  output logic      [4:0]       current_scale_o,
  output logic      [9:0]       load_reading_o,
  output logic                  irq_o
);
  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  lacc_pkg::lacc_cfg_s     cfg_q;
  lacc_pkg::lacc_cfg_s     cfg_d;
  logic [4:0]              run_q;
  logic [4:0]              run_d;
  logic [4:0]              hold_q;
  logic [4:0]              hold_d;
  logic [VEL_W-1:0]        vlow_q;
  logic [VEL_W-1:0]        vlow_d;
  logic [VEL_W-1:0]        upper_velocity_threshold_q;
  logic [VEL_W-1:0]        upper_velocity_threshold_d;
  logic [`LACC_IRQ_W-1:0]  sts_q;
  logic [`LACC_IRQ_W-1:0]  sts_d;
  logic [`LACC_IRQ_W-1:0]  mask_q;
  logic [`LACC_IRQ_W-1:0]  mask_d;
  logic [`LACC_IRQ_W-1:0]  ev;
  logic [31:0]             rdata_q;
  logic [31:0]             rdata_d;
  logic                    irq_q;
  logic                    irq_d;

  // ---------------------------------------------------------------
  // Regulator state
  // ---------------------------------------------------------------
  lacc_pkg::lacc_state_e   state_q;
  lacc_pkg::lacc_state_e   state_d;
  logic [4:0]              scale_q;
  logic [4:0]              scale_d;
  logic [5:0]              cnt_q;
  logic [5:0]              cnt_d;
  logic [9:0]              load_q;
  logic [9:0]              load_d;

  // ---------------------------------------------------------------
  // Sensitivity offset and filter
  // ---------------------------------------------------------------
  logic signed [12:0]      adj_sum;
  lacc_pkg::lacc_meas_s    meas;
  lacc_pkg::lacc_meas_s    filt;

  always_comb
  begin
    // Higher sensitivity setting lifts the reading, so more torque is needed to reach zero
    adj_sum = $signed({3'h0, raw_load_i})
            + $signed({{2{cfg_q.sens[6]}}, cfg_q.sens, 4'h0});
    meas.valid = fullstep_i;
    if (adj_sum < 13'sh0000)
      meas.data = 10'h000;
    else if (adj_sum > 13'sh03ff)
      meas.data = 10'h3ff;
    else
      meas.data = adj_sum[9:0];
  end

  lacc_load_filter #(
    .DW       (10),
    .TAPS_LOG (2)
  ) u_filter (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .en_i      (cfg_q.filt),
    .in_i      (meas),
    .out_o     (filt)
  );

  // ---------------------------------------------------------------
  // Thresholds and limits
  // ---------------------------------------------------------------
  logic [10:0] lower_thr;
  logic [10:0] upper_thr;
  logic [4:0]  inc_amt;
  logic [5:0]  need_cnt;
  logic [4:0]  min_scale;
  logic [4:0]  fixed_scale;
  logic        in_range;
  logic        active;
  logic        below;
  logic        above;
  logic [5:0]  inc_sum;

  always_comb
  begin
    lower_thr = {2'h0, cfg_q.lower, 5'h00};
    upper_thr = {1'b0, 5'(cfg_q.lower) + 5'(cfg_q.hyst) + 5'h01, 5'h00};
    inc_amt   = 5'(5'h01 << cfg_q.inc);
    unique case (cfg_q.dec)
      2'h0: need_cnt = 6'h20;
      2'h1: need_cnt = 6'h08;
      2'h2: need_cnt = 6'h02;
      2'h3: need_cnt = 6'h01;
    endcase
    min_scale   = cfg_q.min_sel ? (run_q >> 2) : (run_q >> 1);
    fixed_scale = standstill_i ? hold_q : run_q;
    in_range    = (velocity_i >= vlow_q) && (velocity_i <= upper_velocity_threshold_q);
    active      = (cfg_q.lower != 4'h0) && in_range;
    below       = {1'b0, filt.data} < lower_thr;
    above       = {1'b0, filt.data} >= upper_thr;
    inc_sum     = {1'b0, scale_q} + {1'b0, inc_amt};
  end

  // ---------------------------------------------------------------
  // Current regulator
  // ---------------------------------------------------------------
  always_comb
  begin
    state_d   = state_q;
    scale_d   = scale_q;
    cnt_d     = cnt_q;
    load_d    = filt.valid ? filt.data : load_q;
    ev        = '0;
    ev[`LACC_IRQ_NEW]   = filt.valid;
    ev[`LACC_IRQ_STALL] = filt.valid && (filt.data == 10'h000);
    unique case (state_q)
      lacc_pkg::LACC_FIXED:
      begin
        scale_d = fixed_scale;
        cnt_d   = '0;
        if (active)
          state_d = lacc_pkg::LACC_ADAPT;
      end
      lacc_pkg::LACC_ADAPT:
      begin
        if (!active)
        begin
          state_d = lacc_pkg::LACC_FIXED;
          scale_d = fixed_scale;
          cnt_d   = '0;
        end
        else
        begin
          if (filt.valid && below)
          begin
            scale_d = (inc_sum > {1'b0, run_q}) ? run_q : inc_sum[4:0];
            cnt_d   = '0;
            ev[`LACC_IRQ_RAISE] = 1'b1;
          end
          else if (filt.valid && above)
          begin
            if (cnt_q + 6'h01 >= need_cnt)
            begin
              scale_d = (scale_q > min_scale) ? scale_q - 5'h01 : scale_q;
              cnt_d   = '0;
              ev[`LACC_IRQ_LOWER] = 1'b1;
            end
            else
              cnt_d = cnt_q + 6'h01;
          end
          else if (filt.valid)
            cnt_d = '0;
          // Settings may move under a running regulator; keep scale inside the window
          if (scale_d > run_q)
            scale_d = run_q;
          else if (scale_d < min_scale)
            scale_d = min_scale;
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------
  always_comb
  begin
    cfg_d   = cfg_q;
    run_d   = run_q;
    hold_d  = hold_q;
    vlow_d  = vlow_q;
    upper_velocity_threshold_d = upper_velocity_threshold_q;
    mask_d  = mask_q;
    sts_d   = sts_q;
    if (wr_i)
    begin
      unique case (addr_i)
        `LACC_OFS_CTRL:
        begin
          cfg_d.lower   = wdata_i[`LACC_CTRL_LOWER_LSB +: 4];
          cfg_d.hyst    = wdata_i[`LACC_CTRL_HYST_LSB +: 4];
          cfg_d.inc     = wdata_i[`LACC_CTRL_INC_LSB +: 2];
          cfg_d.dec     = wdata_i[`LACC_CTRL_DEC_LSB +: 2];
          cfg_d.min_sel = wdata_i[`LACC_CTRL_MIN_BIT];
          cfg_d.filt    = wdata_i[`LACC_CTRL_FILT_BIT];
          cfg_d.sens    = $signed(wdata_i[`LACC_CTRL_SENS_LSB +: 7]);
        end
        `LACC_OFS_CURRENT:
        begin
          run_d  = wdata_i[`LACC_CUR_RUN_LSB +: 5];
          hold_d = wdata_i[`LACC_CUR_HOLD_LSB +: 5];
        end
        `LACC_OFS_VLOW:     vlow_d  = wdata_i[VEL_W-1:0];
        `LACC_OFS_UPPER_VELOCITY_THRESHOLD:    upper_velocity_threshold_d = wdata_i[VEL_W-1:0];
        `LACC_OFS_IRQ_STS:  sts_d   = sts_q & ~wdata_i[`LACC_IRQ_W-1:0];
        `LACC_OFS_IRQ_MASK: mask_d  = wdata_i[`LACC_IRQ_W-1:0];
        default:            sts_d   = sts_q;
      endcase
    end
    // New events beat a clear in the same cycle
    sts_d = sts_d | ev;
    irq_d = |(sts_q & mask_q);

    rdata_d = 32'h0000_0000;
    if (rd_i)
    begin
      unique case (addr_i)
        `LACC_OFS_CTRL:
        begin
          rdata_d[`LACC_CTRL_LOWER_LSB +: 4] = cfg_q.lower;
          rdata_d[`LACC_CTRL_HYST_LSB +: 4]  = cfg_q.hyst;
          rdata_d[`LACC_CTRL_INC_LSB +: 2]   = cfg_q.inc;
          rdata_d[`LACC_CTRL_DEC_LSB +: 2]   = cfg_q.dec;
          rdata_d[`LACC_CTRL_MIN_BIT]        = cfg_q.min_sel;
          rdata_d[`LACC_CTRL_FILT_BIT]       = cfg_q.filt;
          rdata_d[`LACC_CTRL_SENS_LSB +: 7]  = cfg_q.sens;
        end
        `LACC_OFS_CURRENT:
        begin
          rdata_d[`LACC_CUR_RUN_LSB +: 5]  = run_q;
          rdata_d[`LACC_CUR_HOLD_LSB +: 5] = hold_q;
        end
        `LACC_OFS_VLOW:     rdata_d[VEL_W-1:0] = vlow_q;
        `LACC_OFS_UPPER_VELOCITY_THRESHOLD:    rdata_d[VEL_W-1:0] = upper_velocity_threshold_q;
        `LACC_OFS_STATUS:
        begin
          rdata_d[9:0]                        = load_q;
          rdata_d[`LACC_STAT_SCALE_LSB +: 5]  = scale_q;
          rdata_d[`LACC_STAT_ACT_BIT]         = (state_q == lacc_pkg::LACC_ADAPT);
        end
        `LACC_OFS_IRQ_STS:  rdata_d[`LACC_IRQ_W-1:0] = sts_q;
        `LACC_OFS_IRQ_MASK: rdata_d[`LACC_IRQ_W-1:0] = mask_q;
        default:            rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      cfg_q   <= '0;
      run_q   <= `LACC_RST_RUN;
      hold_q  <= `LACC_RST_HOLD;
      vlow_q  <= '0;
      upper_velocity_threshold_q <= '1;
      sts_q   <= '0;
      mask_q  <= '0;
      rdata_q <= 32'h0000_0000;
      irq_q   <= 1'b0;
      state_q <= lacc_pkg::LACC_FIXED;
      scale_q <= `LACC_RST_RUN;
      cnt_q   <= 6'h00;
      load_q  <= 10'h000;
    end
    else
    begin
      cfg_q   <= cfg_d;
      run_q   <= run_d;
      hold_q  <= hold_d;
      vlow_q  <= vlow_d;
      upper_velocity_threshold_q <= upper_velocity_threshold_d;
      sts_q   <= sts_d;
      mask_q  <= mask_d;
      rdata_q <= rdata_d;
      irq_q   <= irq_d;
      state_q <= state_d;
      scale_q <= scale_d;
      cnt_q   <= cnt_d;
      load_q  <= load_d;
    end
  end

  assign rd_data_o       = rdata_q;
  assign current_scale_o = scale_q;
  assign load_reading_o  = load_q;
  assign irq_o           = irq_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence quiet_adapt_s;
    state_q == lacc_pkg::LACC_ADAPT && active && !wr_i;
  endsequence

  scale_ceiling_a: assert property (state_q == lacc_pkg::LACC_ADAPT |-> scale_q <= run_q)
    else $error("scale above run current");
  scale_floor_a: assert property (quiet_adapt_s |=> scale_q >= min_scale)
    else $error("scale below minimum fraction");
  raise_step_a: assert property (quiet_adapt_s ##0 (filt.valid && below)
      |=> scale_q == run_q || scale_q == $past(scale_q) + $past(inc_amt))
    else $error("scale raise step wrong");
  decr_step_a: assert property (quiet_adapt_s ##0 (filt.valid && above && cnt_q + 6'h01 >= need_cnt)
      |=> cnt_q == 6'h00 && (scale_q == $past(scale_q) - 5'h01 || scale_q == min_scale))
    else $error("scale decrement wrong");
  count_clear_a: assert property (quiet_adapt_s ##0 (filt.valid && !above) |=> cnt_q == 6'h00)
    else $error("light-load count not cleared");
  disabled_fixed_a: assert property (cfg_q.lower == 4'h0 && !wr_i ##1 cfg_q.lower == 4'h0
      |=> scale_q == $past(fixed_scale))
    else $error("adaptive control not disabled");
  out_range_a: assert property (!in_range ##1 !in_range |=> scale_q == $past(fixed_scale))
    else $error("fixed current not applied outside velocity range");
  stall_flag_a: assert property (filt.valid && filt.data == 10'h000 |=> sts_q[`LACC_IRQ_STALL] ##1 1'b1)
    else $error("zero reading did not flag");
  status_read_a: assert property (rd_i && addr_i == `LACC_OFS_STATUS
      |=> rd_data_o[9:0] == $past(load_q) && rd_data_o[`LACC_STAT_SCALE_LSB +: 5] == $past(scale_q))
    else $error("status read wrong");
  irq_level_a: assert property (|(sts_q & mask_q) |=> irq_o)
    else $error("interrupt not raised");
endmodule

/* verif/lacc_host_model.sv */
`timescale 1ns/1ps
`include "lacc_defines.svh"
module lacc_host_model (
  input  wire logic        clk_i,
  input  wire logic [31:0] rd_data_i,
  output logic      [7:0]  addr_o,
  output logic      [31:0] wdata_o,
  output logic             wr_o,
  output logic             rd_o,
  output logic             stop_o
);
  initial
  begin
    addr_o  = 8'h00;
    wdata_o = 32'h0;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
    stop_o  = 1'b0;
  end

  // --------------------------------
  // Bus cycles
  // --------------------------------
  // Released address and data are inverted so nothing can live on stale values
  task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    addr_o  <= ~a;
    wdata_o <= ~d;
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clk_i);
    rd_o   <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rd_data_i;
  endtask

  // --------------------------------
  // Stall watch
  // --------------------------------
  // Bounded polling; a stall lasts only one full step, so poll every step
  task automatic watch_stall(input int max_polls, output logic seen);
    logic [31:0] s;
    seen = 1'b0;
    for (int i = 0; i < max_polls && !seen; i++)
    begin
      read_reg(`LACC_OFS_STATUS, s);
      if (s[9:0] === 10'h000)
      begin
        stop_o <= 1'b1;
        seen = 1'b1;
      end
    end
  endtask
endmodule

/* verif/testbench.sv */
`timescale 1ns/1ps
`include "lacc_defines.svh"
module testbench;
  logic        clk_i;
  logic        reset_n_i;
  logic [7:0]  addr_i;
  logic [31:0] wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic [31:0] rd_data_o;
  logic        fullstep_i;
  logic [9:0]  raw_load_i;
  logic [19:0] velocity_i;
  logic        standstill_i;
  logic [4:0]  current_scale_o;
  logic [9:0]  load_reading_o;
  logic        irq_o;
  logic        stop_o;
  logic        seen;
  logic [31:0] d;
  int          fails;
  int          cmp_count;
  bit          m_on;
  int          m_lower, m_hyst, m_inc, m_dec, m_min, m_filt, m_sens, m_cnt, m_fc, m_sum, m_load, m_vlo;
  int          m_run = 31, m_hold = 8, m_vhi = 1048575, m_scale = 31;
  int          req[4] = '{32, 8, 2, 1};
  int          vt[6] = '{150, 250, 50, 0, 200, 100};

  lacc_top #(.VEL_W(20)) lacc_top_inst (
    .clk_i           (clk_i),
    .reset_n_i       (reset_n_i),
    .addr_i          (addr_i),
    .wdata_i         (wdata_i),
    .wr_i            (wr_i),
    .rd_i            (rd_i),
    .rd_data_o       (rd_data_o),
    .fullstep_i      (fullstep_i),
    .raw_load_i      (raw_load_i),
    .velocity_i      (velocity_i),
    .standstill_i    (standstill_i),
    .current_scale_o (current_scale_o),
    .load_reading_o  (load_reading_o),
    .irq_o           (irq_o)
  );

  lacc_host_model lacc_host_model_inst (
    .clk_i     (clk_i),
    .rd_data_i (rd_data_o),
    .addr_o    (addr_i),
    .wdata_o   (wdata_i),
    .wr_o      (wr_i),
    .rd_o      (rd_i),
    .stop_o    (stop_o)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  initial
  begin
    repeat (100000) @(posedge clk_i);
    fails++;
    complete_run();
  end

  // --------------------------------
  // Checking
  // --------------------------------
  task automatic check(input string name, input logic [31:0] seen_v, input logic [31:0] exp);
    cmp_count++;
    if (seen_v !== exp)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", name, exp, seen_v);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] w);
    lacc_host_model_inst.write_reg(a, w);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    lacc_host_model_inst.read_reg(a, v);
    check($sformatf("reg %h", a), v, e);
  endtask

  // --------------------------------
  // Reference model
  // --------------------------------
  function automatic bit m_act();
    return m_lower != 0 && m_vlo <= int'(velocity_i) && int'(velocity_i) <= m_vhi;
  endfunction

  task automatic m_sync();
    int lo;
    lo = m_run >> (m_min + 1);
    // Entering adaptive control starts from the fixed scale of that moment
    if (!m_act() || !m_on)
    begin
      m_scale = standstill_i ? m_hold : m_run;
      m_cnt = 0;
    end
    m_on = m_act();
    if (m_on && m_scale > m_run)
      m_scale = m_run;
    else if (m_on && m_scale < lo)
      m_scale = lo;
  endtask

  task automatic m_read(input int raw);
    int v;
    v = raw + m_sens * 16;
    v = v < 0 ? 0 : (v > 1023 ? 1023 : v);
    if (m_filt != 0)
    begin
      m_sum += v;
      m_fc++;
      if (m_fc < 4)
        return;
      v = m_sum >> 2;
      m_sum = 0;
      m_fc = 0;
    end
    m_load = v;
    if (m_act())
    begin
      if (v < m_lower * 32)
      begin
        m_scale += 1 << m_inc;
        m_cnt = 0;
      end
      else if (v >= (m_lower + m_hyst + 1) * 32)
      begin
        m_cnt++;
        if (m_cnt >= req[m_dec])
        begin
          m_scale--;
          m_cnt = 0;
        end
      end
      else
        m_cnt = 0;
    end
    m_sync();
  endtask

  // --------------------------------
  // Stimulus
  // --------------------------------
  task automatic chk_out();
    #1;
    check("scale", 32'(current_scale_o), 32'(m_scale));
    check("load", 32'(load_reading_o), 32'(m_load));
  endtask

  task automatic step(input int raw);
    @(posedge clk_i);
    fullstep_i <= 1'b1;
    raw_load_i <= 10'(raw);
    @(posedge clk_i);
    fullstep_i <= 1'b0;
    raw_load_i <= ~10'(raw);
    m_read(raw);
    repeat (2) @(posedge clk_i);
    chk_out();
  endtask

  task automatic set_ctrl(input int lo, hy, in, dn, mn, fl, se);
    wreg(`LACC_OFS_CTRL, {9'h0, 7'(se), 2'b0, 1'(fl), 1'(mn), 2'(dn), 2'(in), 4'(hy), 4'(lo)});
    m_lower = lo;
    m_hyst = hy;
    m_inc = in;
    m_dec = dn;
    m_min = mn;
    m_filt = fl;
    m_sens = se;
    if (fl == 0)
      m_fc = 0;
    if (fl == 0)
      m_sum = 0;
    m_sync();
    repeat (2) @(posedge clk_i);
    chk_out();
  endtask

  task automatic set_vel(input int v, input logic ss);
    @(posedge clk_i);
    velocity_i   <= 20'(v);
    standstill_i <= ss;
    repeat (3) @(posedge clk_i);
    m_sync();
    chk_out();
  endtask

  initial
  begin
    reset_n_i = 1'b0;
    fullstep_i = 1'b0;
    raw_load_i = 10'h000;
    velocity_i = 20'h00096;
    standstill_i = 1'b0;
    void'($urandom(44));
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    chk_out();
    rd_chk(`LACC_OFS_CTRL, 32'h0);
    rd_chk(`LACC_OFS_CURRENT, 32'h0000081f);
    rd_chk(`LACC_OFS_UPPER_VELOCITY_THRESHOLD, 32'h000fffff);
    rd_chk(8'h1c, 32'h0);
    wreg(`LACC_OFS_STATUS, 32'hffffffff);
    rd_chk(`LACC_OFS_STATUS, 32'h001f0000);
    // Interrupt: set, masked, unmasked, cleared
    step(700);
    rd_chk(`LACC_OFS_IRQ_STS, 32'h1);
    check("irq", 32'(irq_o), 32'h0);
    wreg(`LACC_OFS_IRQ_MASK, 32'hf);
    repeat (2) @(posedge clk_i);
    #1 check("irq", 32'(irq_o), 32'h1);
    wreg(`LACC_OFS_IRQ_STS, 32'hf);
    repeat (2) @(posedge clk_i);
    #1 check("irq", 32'(irq_o), 32'h0);
    // Stall: sensitivity first, then a reading driven to zero
    set_ctrl(0, 0, 0, 0, 0, 0, -1);
    step(700);
    step(5);
    lacc_host_model_inst.watch_stall(4, seen);
    // The stop request lands by non-blocking assignment; let it settle first
    #1 check("stop", {31'h0, stop_o & seen}, 32'h1);
    rd_chk(`LACC_OFS_IRQ_STS, 32'h3);
    wreg(`LACC_OFS_IRQ_STS, 32'hf);
    // Adaptive regulation over every increment and decrement code
    wreg(`LACC_OFS_CURRENT, 32'h00000818);
    m_run = 24;
    m_sync();
    for (int k = 0; k < 4; k++)
    begin
      set_ctrl(2, k, k, 3 - k, k % 2, 0, k == 2 ? -1 : k);
      for (int i = 0; i < 64; i++)
        step(i < 40 ? 600 + $urandom_range(423) : $urandom_range(1023));
    end
    // A heavy load reading guarantees at least one raise whatever the seed gave
    step(0);
    lacc_host_model_inst.read_reg(`LACC_OFS_IRQ_STS, d);
    check("raise lower", d & 32'hd, 32'hd);
    rd_chk(`LACC_OFS_STATUS, {7'h0, 1'b1, 3'h0, 5'(m_scale), 6'h0, 10'(m_load)});
    // Filtered readings, with a disable in mid-group
    set_ctrl(2, 1, 1, 3, 0, 1, 0);
    for (int i = 0; i < 22; i++)
    begin
      if (i == 14 || i == 15)
        set_ctrl(2, 1, 1, 3, 0, i - 14, 0);
      step($urandom_range(1023));
    end
    // Velocity window, inclusive at both ends
    set_ctrl(2, 0, 0, 3, 1, 0, 0);
    wreg(`LACC_OFS_VLOW, 32'h64);
    wreg(`LACC_OFS_UPPER_VELOCITY_THRESHOLD, 32'hc8);
    m_vlo = 100;
    m_vhi = 200;
    foreach (vt[j])
    begin
      set_vel(vt[j], vt[j] == 0);
      step(900);
      step(900);
    end
    complete_run();
  end
endmodule
